//--- logic/dual_comm_watchdog.sv
// Dual communication watchdog: bus-side and application-interface timers with shared tick.
// Assumes an APB master on pclk (250 MHz) and synchronous event strobes from the controller.
//
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/10ps

// Operation
// - Bus-side timer restarts only on each completed bus process data exchange.
// - Bus-side timer expiry, when enabled, forces all outputs to off.
// - Bus-side trip leaves the operational state untouched; outputs only.
// - Application timer trips without local interface traffic beyond its timeout.
// - Both timers default to 100 ms after power-up.
// - One multiplier sets the tick of both timers.
// - Each timer has its own tick count; count times tick gives timeout.
// - Tick lasts multiplier plus two base periods of the 25 MHz clock.
// - Each base period is 40 ns.
// - Multiplier resets to 2498, a 100 us tick.
// - Bus-side tick count resets to 1000, giving 100 ms.
// - Bus-side count 0..65535 and multiplier 1..65535 accepted.
// - Enabled bus-side timer with count zero never trips.
// - Without a start-up download, settings stay as they were.
module dual_comm_watchdog
    import wdog_pkg::*;
(
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Traffic events
    input wire logic bus_exchange_ok,
    input wire logic local_process_interface_access,
    // Process outputs
    input wire logic [7:0] out_request,
    output logic [7:0] out_drive,
    // Slave state passthrough
    input wire logic operational_state,
    output logic operational_state_out,
    // Interrupt
    output logic irq
);
    logic [3:0] ctrl;
    logic [15:0] mult;
    logic [15:0] bus_ticks;
    logic [15:0] app_ticks;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic [3:0] base_cnt;
    logic base_tick;
    logic [16:0] mult_cnt;
    logic wd_tick;
    logic bus_tripped;
    logic app_tripped;
    logic bus_trip_pulse;
    logic app_trip_pulse;
    logic wr_en;
    logic rd_en;
    logic cfg_open;
    logic addr_ok;
    logic [16:0] tick_last;
    apb_rsp_s rsp;

    // Single-cycle access phase; no wait states
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    // Settings are writable only during start-up with manual configuration on
    assign cfg_open = ctrl[CTRL_MANUAL_CFG] && !ctrl[CTRL_STARTUP_DONE];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= CTRL_RESET;
        end else if (wr_en && paddr == OFF_CTRL) begin
            // Start-up done is sticky until reset
            ctrl <= {ctrl[CTRL_STARTUP_DONE] | pwdata[CTRL_STARTUP_DONE], pwdata[2:0]};
        end
    end

    // Defaults stand unless a start-up download replaces them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mult <= MULT_RESET;
            bus_ticks <= BUS_TICKS_RESET;
            app_ticks <= APP_TICKS_RESET;
        end else if (wr_en && cfg_open) begin
            if (paddr == OFF_MULT && pwdata[15:0] >= MULT_MIN) begin
                mult <= pwdata[15:0];
            end
            if (paddr == OFF_BUS_TICKS) begin
                bus_ticks <= pwdata[15:0];
            end
            if (paddr == OFF_APP_TICKS) begin
                app_ticks <= pwdata[15:0];
            end
        end
    end

    // 25 MHz base enable from 250 MHz pclk
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            base_cnt <= 4'h0;
        end else if (base_cnt == BASE_DIV_LAST) begin
            base_cnt <= 4'h0;
        end else begin
            base_cnt <= base_cnt + 4'h1;
        end
    end
    assign base_tick = (base_cnt == BASE_DIV_LAST);

    // Watchdog tick every mult + 2 base periods
    assign tick_last = {1'b0, mult} + 17'(MULT_EXTRA - 1);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mult_cnt <= 17'h00000;
        end else if (base_tick) begin
            if (mult_cnt >= tick_last) begin
                mult_cnt <= 17'h00000;
            end else begin
                mult_cnt <= mult_cnt + 17'h00001;
            end
        end
    end
    assign wd_tick = base_tick && (mult_cnt >= tick_last);

    wdog_timer bus_side_watchdog (
        .pclk(pclk),
        .presetn(presetn),
        .enable(ctrl[CTRL_BUS_EN]),
        .zero_disables(1'b1),
        .limit(bus_ticks),
        .tick(wd_tick),
        .restart(bus_exchange_ok),
        .tripped(bus_tripped),
        .trip_pulse(bus_trip_pulse)
    );

    // Zero count on this side also means disabled, a trip at zero has no meaning
    wdog_timer app_interface_watchdog (
        .pclk(pclk),
        .presetn(presetn),
        .enable(ctrl[CTRL_APP_EN]),
        .zero_disables(1'b1),
        .limit(app_ticks),
        .tick(wd_tick),
        .restart(local_process_interface_access),
        .tripped(app_tripped),
        .trip_pulse(app_trip_pulse)
    );

    // Outputs registered; forced low while either side is tripped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_drive <= 8'h00;
        end else if (bus_tripped || app_tripped) begin
            out_drive <= 8'h00;
        end else begin
            out_drive <= out_request;
        end
    end

    // State is passed unchanged, a trip never touches it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            operational_state_out <= 1'b0;
        end else begin
            operational_state_out <= operational_state;
        end
    end

    // Sticky events; a new trip in the read cycle survives the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= 2'h0;
        end else begin
            irq_status <= (rd_en && paddr == OFF_IRQ_STATUS ? 2'h0 : irq_status)
                | {app_trip_pulse, bus_trip_pulse};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask <= 2'h0;
        end else if (wr_en && paddr == OFF_IRQ_MASK) begin
            irq_mask <= pwdata[1:0];
        end
    end

    assign irq = |(irq_status & irq_mask);

    always_comb begin
        addr_ok = 1'b1;
        rsp.prdata = 32'h00000000;
        case (paddr)
            OFF_CTRL: rsp.prdata = {28'h0000000, ctrl};
            OFF_MULT: rsp.prdata = {16'h0000, mult};
            OFF_BUS_TICKS: rsp.prdata = {16'h0000, bus_ticks};
            OFF_APP_TICKS: rsp.prdata = {16'h0000, app_ticks};
            OFF_STATUS: rsp.prdata = {30'h00000000, app_tripped, bus_tripped};
            OFF_IRQ_STATUS: rsp.prdata = {30'h00000000, irq_status};
            OFF_IRQ_MASK: rsp.prdata = {30'h00000000, irq_mask};
            default: addr_ok = 1'b0;
        endcase
        rsp.pready = 1'b1;
        rsp.pslverr = psel && penable && !addr_ok;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rsp.prdata;
        end
    end
    assign pready = rsp.pready;
    assign pslverr = rsp.pslverr;
endmodule

//--- logic/wdog_pkg.sv
// Package for the dual communication watchdog: register map, reset values, timing.
// Assumes an APB slave with 32-bit data and one word per register.
package wdog_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_MULT = 8'h04;
    localparam logic [7:0] OFF_BUS_TICKS = 8'h08;
    localparam logic [7:0] OFF_APP_TICKS = 8'h0c;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h14;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h18;

    // Control register fields
    localparam int CTRL_BUS_EN = 0;
    localparam int CTRL_APP_EN = 1;
    localparam int CTRL_MANUAL_CFG = 2;
    localparam int CTRL_STARTUP_DONE = 3;

    // Status / interrupt fields
    localparam int ST_BUS_TRIP = 0;
    localparam int ST_APP_TRIP = 1;

    // Reset values
    localparam logic [15:0] MULT_RESET = 16'h09c2;
    localparam logic [15:0] BUS_TICKS_RESET = 16'h03e8;
    localparam logic [15:0] APP_TICKS_RESET = 16'h03e8;
    localparam logic [3:0] CTRL_RESET = 4'h3;
    localparam logic [15:0] MULT_MIN = 16'h0001;

    // Base clock 25 MHz, 40 ns period; pclk 250 MHz, 4 ns period
    localparam int BASE_PERIOD_NS = 40;
    localparam int PCLK_PERIOD_NS = 4;
    localparam int BASE_DIV = BASE_PERIOD_NS / PCLK_PERIOD_NS;
    localparam logic [3:0] BASE_DIV_LAST = 4'(BASE_DIV - 1);
    localparam int MULT_EXTRA = 2;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_s;

endpackage

//--- logic/wdog_timer.sv
// One watchdog timer channel: counts shared ticks, trips at the configured count.
// Assumes tick is a one-cycle enable from the shared divider.
`timescale 1ns/10ps
module wdog_timer
    import wdog_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic enable,
    input wire logic zero_disables,
    input wire logic [15:0] limit,
    input wire logic tick,
    input wire logic restart,
    // State
    output logic tripped,
    output logic trip_pulse
);
    logic [15:0] count;
    logic off;
    logic next_trip;

    assign off = !enable || (zero_disables && limit == 16'h0000);
    assign next_trip = !off && !tripped && tick && (count + 16'h0001 >= limit);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= 16'h0000;
        end else if (restart || off) begin
            count <= 16'h0000;
        end else if (tick && !tripped && count != 16'hffff) begin
            count <= count + 16'h0001;
        end
    end

    // Restart and trip in the same cycle: restart wins, the trip is dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tripped <= 1'b0;
            trip_pulse <= 1'b0;
        end else begin
            trip_pulse <= next_trip && !restart;
            if (restart || off) begin
                tripped <= 1'b0;
            end else if (next_trip) begin
                tripped <= 1'b1;
            end
        end
    end
endmodule

//--- verification/dual_comm_watchdog_properties.sv
// Port checker for the dual communication watchdog.
// Assumes a bind onto the top module; one pclk domain.
`timescale 1ns/10ps
module dual_comm_watchdog_properties (
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Traffic and outputs
    input wire logic bus_exchange_ok,
    input wire logic local_process_interface_access,
    input wire logic [7:0] out_request,
    input wire logic [7:0] out_drive,
    input wire logic operational_state,
    input wire logic operational_state_out,
    input wire logic irq
);
    logic acc;
    logic hit;
    assign acc = psel && penable;
    assign hit = paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_pready_high: assert property (pready) else $error("pready low");
    a_unmapped_err: assert property (acc && !hit |-> pslverr) else $error("no error");
    a_unmapped_zero: assert property (acc && !pwrite && !hit |-> prdata == 32'h0)
        else $error("unmapped data");
    a_upper_zero: assert property (acc && !pwrite |-> prdata[31:16] == 16'h0)
        else $error("upper bits set");
    a_drive_follows: assert property (out_drive != 8'h0 |-> out_drive == $past(out_request))
        else $error("drive mismatch");
    a_state_kept: assert property ($past(presetn, 2) |-> operational_state_out == $past(operational_state))
        else $error("state altered");
    a_restart_release: assert property (bus_exchange_ok && local_process_interface_access
        |=> ##1 out_drive == $past(out_request)) else $error("outputs held off");
    a_reset_quiet: assert property ($rose(presetn) |-> out_drive == 8'h0 && !irq)
        else $error("outputs after reset");
    c_forced_off: cover property (out_drive == 8'h0 && out_request != 8'h0);
    c_irq: cover property (irq);
    c_unmapped: cover property (acc && pslverr);
endmodule

//--- verification/dual_comm_watchdog_tb.sv
// Self-checking bench for the dual communication watchdog.
// Assumes the partner model supplies traffic; registers are reached over APB.
`timescale 1ns/10ps
module dual_comm_watchdog_tb
    import wdog_pkg::*;
;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, bus_on = 0, app_on = 0, err;
    logic operational_state = 1;
    logic [7:0] paddr = 0, out_request = 8'ha5, out_drive;
    logic [31:0] pwdata = 0, rd, prdata;
    logic pready, pslverr, irq, operational_state_out, bus_exchange_ok, local_process_interface_access;
    int failures = 0, cmp_count = 0, cyc = 0, t0;
    logic [7:0] addrs [6] = '{OFF_CTRL, OFF_MULT, OFF_BUS_TICKS, OFF_APP_TICKS, OFF_IRQ_MASK, 8'h1c};
    logic [31:0] exps [6] = '{32'h3, 32'h9c2, 32'h3e8, 32'h3e8, 32'h0, 32'h0};
    dual_comm_watchdog i_dual_comm_watchdog (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .bus_exchange_ok, .local_process_interface_access, .out_request, .out_drive,
        .operational_state, .operational_state_out, .irq);
    wdog_partner i_wdog_partner (.pclk, .presetn, .bus_on, .app_on, .bus_exchange_ok,
        .local_process_interface_access);
    initial forever #2 pclk = ~pclk;
    always @(posedge pclk) cyc <= cyc + 1;
    task automatic summarize;
        if (failures == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            failures++;
            summarize();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic poll(input logic [31:0] m);
        int n;
        n = 0;
        do begin
            apb(1'b0, OFF_STATUS, 32'h0);
            n++;
        end while ((rd & m) !== m && n < 100);
        if (n >= 100) begin
            failures++;
            summarize();
        end
    endtask
    // Short ticks: multiplier 1 gives 30 pclk per tick
    task automatic setup(input logic [15:0] bt, input logic [15:0] at);
        apb(1'b1, OFF_CTRL, 32'h7);
        apb(1'b1, OFF_MULT, 32'h1);
        apb(1'b1, OFF_BUS_TICKS, {16'h0, bt});
        apb(1'b1, OFF_APP_TICKS, {16'h0, at});
        apb(1'b1, OFF_IRQ_MASK, 32'h3);
        apb(1'b1, OFF_CTRL, 32'hf);
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        failures++;
        summarize();
    end
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        foreach (addrs[i]) begin
            apb(1'b0, addrs[i], 32'h0);
            chk("reset value", rd, exps[i]);
        end
        chk("unmapped error", {31'h0, err}, 32'h1);
        // Traffic first, so the jump to short ticks cannot trip a silent timer
        bus_on <= 1'b1;
        app_on <= 1'b1;
        setup(16'h2, 16'h3);
        apb(1'b1, OFF_MULT, 32'h20);
        apb(1'b0, OFF_MULT, 32'h0);
        chk("multiplier locked", rd, 32'h1);
        repeat (300) @(posedge pclk);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk("status with traffic", rd, 32'h0);
        chk("outputs live", {24'h0, out_drive}, 32'ha5);
        bus_on <= 1'b0;
        t0 = cyc;
        poll(32'h1);
        chk("bus trip time", {31'h0, (cyc - t0) inside {[20:68]}}, 32'h1);
        chk("outputs off", {24'h0, out_drive}, 32'h0);
        chk("state kept", {31'h0, operational_state_out}, 32'h1);
        chk("irq raised", {31'h0, irq}, 32'h1);
        apb(1'b0, OFF_IRQ_STATUS, 32'h0);
        chk("irq status", rd, 32'h1);
        apb(1'b0, OFF_IRQ_STATUS, 32'h0);
        chk("irq status cleared", rd, 32'h0);
        chk("irq dropped", {31'h0, irq}, 32'h0);
        bus_on <= 1'b1;
        repeat (15) @(posedge pclk);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk("bus trip cleared", rd, 32'h0);
        apb(1'b1, OFF_IRQ_MASK, 32'h1);
        app_on <= 1'b0;
        t0 = cyc;
        poll(32'h2);
        // Three ticks of 30 pclk; first tick phase free, last restart up to 10 cycles early
        chk("app trip time", {31'h0, (cyc - t0) inside {[50:96]}}, 32'h1);
        chk("app trip only", rd, 32'h2);
        chk("irq masked", {31'h0, irq}, 32'h0);
        operational_state <= 1'b0;
        out_request <= 8'h3c;
        repeat (3) @(posedge pclk);
        chk("state follows in trip", {31'h0, operational_state_out}, 32'h0);
        chk("outputs held off", {24'h0, out_drive}, 32'h0);
        app_on <= 1'b1;
        presetn <= 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b1, OFF_CTRL, 32'h7);
        apb(1'b1, OFF_MULT, 32'h0);
        apb(1'b1, OFF_BUS_TICKS, 32'hffff);
        apb(1'b0, OFF_MULT, 32'h0);
        chk("multiplier zero refused", rd, 32'h9c2);
        apb(1'b0, OFF_BUS_TICKS, 32'h0);
        chk("full count accepted", rd, 32'hffff);
        setup(16'h0, 16'h0);
        bus_on <= 1'b0;
        app_on <= 1'b0;
        repeat (300) @(posedge pclk);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk("zero count status", rd, 32'h0);
        chk("zero count outputs", {24'h0, out_drive}, 32'h3c);
        summarize();
    end
endmodule
bind dual_comm_watchdog dual_comm_watchdog_properties i_dual_comm_watchdog_properties (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .bus_exchange_ok, .local_process_interface_access,
    .out_request, .out_drive, .operational_state, .operational_state_out, .irq);

//--- verification/wdog_partner.sv
// Traffic model of the fieldbus master and the local processor.
// Assumes the bench gates each source; strobes align to exercise joint restarts.
`timescale 1ns/10ps
module wdog_partner (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Traffic enables
    input wire logic bus_on,
    input wire logic app_on,
    // Strobes
    output logic bus_exchange_ok,
    output logic local_process_interface_access
);
    logic [3:0] cnt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 4'h0;
            bus_exchange_ok <= 1'b0;
            local_process_interface_access <= 1'b0;
        end else begin
            cnt <= (cnt == 4'h9) ? 4'h0 : cnt + 4'h1;
            bus_exchange_ok <= bus_on && cnt == 4'h0;
            local_process_interface_access <= app_on && cnt == 4'h0;
        end
    end
endmodule
